// ==== logic/ifsb_pkg.sv ====
// Package with register map, field positions and carrier types of the interrupt flag bank.
package ifsb_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [11:0] ADDR_FLAG_STATUS_0 = 12'h000;
	localparam logic [11:0] ADDR_FLAG_STATUS_1 = 12'h004;
	localparam logic [15:0] FLAG_RESET         = 16'h0000;

	// Implemented positions of each register; all other bits read zero.
	localparam logic [15:0] MASK_FLAG_STATUS_0 = 16'h3fef;
	localparam logic [15:0] MASK_FLAG_STATUS_1 = 16'hfe1f;

	// ********************************************************************
	// Field positions, register 0
	// ********************************************************************
	localparam int unsigned POS_TIMER_ONE   = 3;
	localparam int unsigned POS_TIMER_TWO   = 7;

	// ********************************************************************
	// Field positions, register 1
	// ********************************************************************
	localparam int unsigned POS_SER2_TX     = 15;
	localparam int unsigned POS_SER2_RX     = 14;
	localparam int unsigned POS_EXT_TWO     = 13;
	localparam int unsigned POS_TIMER_FIVE  = 12;
	localparam int unsigned POS_TIMER_FOUR  = 11;
	localparam int unsigned POS_CMP_FOUR    = 10;
	localparam int unsigned POS_CMP_THREE   = 9;
	localparam int unsigned POS_EXT_ONE     = 4;
	localparam int unsigned POS_CHANGE      = 3;
	localparam int unsigned POS_COMPARATOR  = 2;
	localparam int unsigned POS_I2C_MASTER  = 1;
	localparam int unsigned POS_I2C_SLAVE   = 0;

	// ********************************************************************
	// Carrier types
	// ********************************************************************
	// Event pulses, one bit per flag position, same layout as the registers.
	typedef struct packed
	{
		logic [15:0] status_0;
		logic [15:0] status_1;
	} ifsb_events_s;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ifsb_apb_req_s;

endpackage

// ==== logic/ifsb_flag_bank.sv ====
// Interrupt flag status bank with APB register access.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - A flag sets when its source requests while the clock enable is high and stays set until cleared.
// - A clear flag stays zero while no request from its source is pending and no write sets it.
// - Register one bit 14 holds the second serial receiver flag.
// - Register one bit 13 holds the external pin two flag.
// - Register one bit 12 holds the fifth timer flag.
// - Register one bit 11 holds the fourth timer flag.
// - Register one bit 3 holds the change notification flag.
// - Register one bit 4 holds the external pin one flag.
module ifsb_flag_bank
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire ifsb_pkg::ifsb_apb_req_s apb_req,
	output logic                       pready,
	output logic                       pslverr,
	output logic [31:0]                prdata,
	input  wire ifsb_pkg::ifsb_events_s  events,
	output logic [15:0]                interrupt_flag_status_0,
	output logic [15:0]                interrupt_flag_status_1
);

	// ********************************************************************
	// Bus decode
	// ********************************************************************
	logic access;
	logic hit_0;
	logic hit_1;
	logic wr_0;
	logic wr_1;

	// Every access completes in its first access cycle, so pready is a plain decode.
	assign access  = apb_req.psel && apb_req.penable;
	assign hit_0   = apb_req.paddr == ifsb_pkg::ADDR_FLAG_STATUS_0;
	assign hit_1   = apb_req.paddr == ifsb_pkg::ADDR_FLAG_STATUS_1;
	assign wr_0    = access && apb_req.pwrite && hit_0 && clk_en;
	assign wr_1    = access && apb_req.pwrite && hit_1 && clk_en;
	assign pready  = access;
	assign pslverr = access && !(hit_0 || hit_1); // Unmapped addresses answer with an error.

	// ********************************************************************
	// Flag registers
	// ********************************************************************
	logic [15:0] next_flag_0;
	logic [15:0] next_flag_1;
	logic [31:0] next_prdata;

	// Software write lands first, then hardware events OR on top, so a set in the
	// clearing cycle is never lost. Unimplemented positions are masked to zero.
	always_comb
	begin
		next_flag_0 = interrupt_flag_status_0;
		next_flag_1 = interrupt_flag_status_1;
		next_prdata = prdata;
		if (wr_0)
			next_flag_0 = apb_req.pwdata[15:0];
		if (wr_1)
			next_flag_1 = apb_req.pwdata[15:0];
		next_flag_0 = (next_flag_0 | events.status_0) & ifsb_pkg::MASK_FLAG_STATUS_0;
		next_flag_1 = (next_flag_1 | events.status_1) & ifsb_pkg::MASK_FLAG_STATUS_1;
		// Read data is registered in the setup cycle so it is stable through access.
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
		begin
			if (apb_req.paddr == ifsb_pkg::ADDR_FLAG_STATUS_0)
				next_prdata = {16'h0000, interrupt_flag_status_0};
			else if (apb_req.paddr == ifsb_pkg::ADDR_FLAG_STATUS_1)
				next_prdata = {16'h0000, interrupt_flag_status_1};
			else
				next_prdata = 32'h0000_0000;
		end
	end

	// Flags clear on reset and hold while the clock enable is low.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			interrupt_flag_status_0 <= ifsb_pkg::FLAG_RESET;
			interrupt_flag_status_1 <= ifsb_pkg::FLAG_RESET;
			prdata                  <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			interrupt_flag_status_0 <= next_flag_0;
			interrupt_flag_status_1 <= next_flag_1;
			prdata                  <= next_prdata;
		end
	end

	// ********************************************************************
	// Named flag views
	// ********************************************************************
	// One name per flag position of register one and for bits 3 and 7 of register zero, so each
	// named position is pinned down by its own assertion and a slip in one cannot hide behind the others.
	logic timer_one_flag;
	logic timer_two_flag;
	logic serial2_transmit_flag;
	logic serial2_receive_flag;
	logic ext_pin_two_flag;
	logic timer_five_flag;
	logic timer_four_flag;
	logic compare_four_flag;
	logic compare_three_flag;
	logic ext_pin_one_flag;
	logic change_notify_flag;
	logic comparator_flag;
	logic i2c_master_event_flag;
	logic i2c_slave_event_flag;

	// Register zero positions.
	assign timer_one_flag        = interrupt_flag_status_0[ifsb_pkg::POS_TIMER_ONE];
	assign timer_two_flag        = interrupt_flag_status_0[ifsb_pkg::POS_TIMER_TWO];

	// Register one positions.
	assign serial2_transmit_flag = interrupt_flag_status_1[ifsb_pkg::POS_SER2_TX];
	assign serial2_receive_flag  = interrupt_flag_status_1[ifsb_pkg::POS_SER2_RX];
	assign ext_pin_two_flag      = interrupt_flag_status_1[ifsb_pkg::POS_EXT_TWO];
	assign timer_five_flag       = interrupt_flag_status_1[ifsb_pkg::POS_TIMER_FIVE];
	assign timer_four_flag       = interrupt_flag_status_1[ifsb_pkg::POS_TIMER_FOUR];
	assign compare_four_flag     = interrupt_flag_status_1[ifsb_pkg::POS_CMP_FOUR];
	assign compare_three_flag    = interrupt_flag_status_1[ifsb_pkg::POS_CMP_THREE];
	assign ext_pin_one_flag      = interrupt_flag_status_1[ifsb_pkg::POS_EXT_ONE];
	assign change_notify_flag    = interrupt_flag_status_1[ifsb_pkg::POS_CHANGE];
	assign comparator_flag       = interrupt_flag_status_1[ifsb_pkg::POS_COMPARATOR];
	assign i2c_master_event_flag = interrupt_flag_status_1[ifsb_pkg::POS_I2C_MASTER];
	assign i2c_slave_event_flag  = interrupt_flag_status_1[ifsb_pkg::POS_I2C_SLAVE];

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// A request taken with the clock enable high shows in its flag one cycle later.
	timer_one_set_a: assert property (
		clk_en && events.status_0[ifsb_pkg::POS_TIMER_ONE] |=> timer_one_flag)
		else $error("Timer one flag did not set.");
	timer_two_set_a: assert property (
		clk_en && events.status_0[ifsb_pkg::POS_TIMER_TWO] |=> timer_two_flag)
		else $error("Timer two flag did not set.");
	serial_tx_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_SER2_TX] |=> serial2_transmit_flag)
		else $error("Serial transmit flag did not set.");
	serial_rx_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_SER2_RX] |=> serial2_receive_flag)
		else $error("Serial receive flag did not set.");
	ext_two_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_EXT_TWO] |=> ext_pin_two_flag)
		else $error("External pin two flag did not set.");
	timer_five_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_TIMER_FIVE] |=> timer_five_flag)
		else $error("Timer five flag did not set.");
	timer_four_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_TIMER_FOUR] |=> timer_four_flag)
		else $error("Timer four flag did not set.");
	compare_four_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_CMP_FOUR] |=> compare_four_flag)
		else $error("Compare four flag did not set.");
	compare_three_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_CMP_THREE] |=> compare_three_flag)
		else $error("Compare three flag did not set.");
	ext_one_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_EXT_ONE] |=> ext_pin_one_flag)
		else $error("External pin one flag did not set.");
	change_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_CHANGE] |=> change_notify_flag)
		else $error("Change notification flag did not set.");
	comparator_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_COMPARATOR] |=> comparator_flag)
		else $error("Comparator flag did not set.");
	i2c_master_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_I2C_MASTER] |=> i2c_master_event_flag)
		else $error("Bus master event flag did not set.");
	i2c_slave_set_a: assert property (
		clk_en && events.status_1[ifsb_pkg::POS_I2C_SLAVE] |=> i2c_slave_event_flag)
		else $error("Bus slave event flag did not set.");

	// A set flag holds until a write to its register; only the write may drop it.
	flag_sticky_a: assert property (
		$past(timer_four_flag) && !$past(wr_1) |-> timer_four_flag)
		else $error("Flag dropped without a write.");

	// With no request taken and no write, a clear flag stays clear.
	idle_zero_a: assert property (
		(!clk_en || (!events.status_0[ifsb_pkg::POS_TIMER_TWO] && !wr_0)) && !timer_two_flag
		|=> !timer_two_flag)
		else $error("Flag set with no pending request.");

	// Unimplemented positions never read as one.
	unimpl_zero_a: assert property (
		((interrupt_flag_status_0 & ~ifsb_pkg::MASK_FLAG_STATUS_0) == 16'h0000)
		&& ((interrupt_flag_status_1 & ~ifsb_pkg::MASK_FLAG_STATUS_1) == 16'h0000))
		else $error("Unimplemented bit read as one.");

	// A write stores its data: a zero clears unless an event wins, a one sets.
	write_clear_a: assert property (
		wr_1 && !apb_req.pwdata[ifsb_pkg::POS_I2C_SLAVE] && !events.status_1[ifsb_pkg::POS_I2C_SLAVE]
		|=> !i2c_slave_event_flag)
		else $error("Write of zero did not clear flag.");
	write_set_a: assert property (
		wr_0 && apb_req.pwdata[ifsb_pkg::POS_TIMER_ONE] |=> timer_one_flag)
		else $error("Write of one did not set flag.");

	// While the clock enable is low, flags and read data hold.
	freeze_hold_a: assert property (
		!clk_en |=> $stable(interrupt_flag_status_0) && $stable(interrupt_flag_status_1) && $stable(prdata))
		else $error("State moved while the clock enable was low.");

	// A read setup loads the addressed register into the read data.
	read_load_a: assert property (
		clk_en && apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_1
		|=> prdata == {16'h0000, $past(interrupt_flag_status_1)})
		else $error("Read data does not match register one.");

	// Main scenarios that the bench is meant to reach.
	write_cov: cover property (wr_1);
	event_cov: cover property (clk_en && events.status_1[ifsb_pkg::POS_SER2_RX]);
	set_clear_cov: cover property (wr_0 && events.status_0[ifsb_pkg::POS_TIMER_ONE]);
	error_cov: cover property (pslverr);
	freeze_cov: cover property (!clk_en && events.status_0[ifsb_pkg::POS_TIMER_ONE]);

endmodule

// ==== tb/ifsb_flag_bank_tb.sv ====
// Self-checking testbench for the interrupt flag status bank.
`timescale 1ns/1ps
module ifsb_flag_bank_tb;
	localparam logic [11:0] A0 = ifsb_pkg::ADDR_FLAG_STATUS_0;
	localparam logic [11:0] A1 = ifsb_pkg::ADDR_FLAG_STATUS_1;
	logic                    ref_clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    clk_en = 1'b1;
	ifsb_pkg::ifsb_apb_req_s apb_req = '0;
	ifsb_pkg::ifsb_events_s  events = '0;
	logic                    pready;
	logic                    pslverr;
	logic [31:0]             prdata;
	logic [15:0]             flag_0;
	logic [15:0]             flag_1;
	logic [31:0]             rd;
	logic                    err;
	int                      n_mismatch = 0;
	int                      cmp_count = 0;
	ifsb_flag_bank dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .apb_req(apb_req), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .events(events), .interrupt_flag_status_0(flag_0),
		.interrupt_flag_status_1(flag_1));
	// Free running clock at 25 MHz.
	always #20 ref_clk = ~ref_clk;
	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer; the bound on the wait keeps a dead slave from hanging the run.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	// ********************************************************************
	// Scenarios
	// ********************************************************************
	// Writes of all ones show which positions exist; writes of zero clear them.
	task write_masks;
		apb(1'b1, A0, 32'hffffffff);
		apb(1'b1, A1, 32'hffffffff);
		apb(1'b0, A0, 32'h0);
		chk("status_0 implemented bits", 32'h00003fef, rd);
		apb(1'b0, A1, 32'h0);
		chk("status_1 implemented bits", 32'h0000fe1f, rd);
		apb(1'b1, A0, 32'h0);
		apb(1'b1, A1, 32'h0);
		apb(1'b0, A1, 32'h0);
		chk("status_1 cleared", 32'h0, rd);
		chk("status_0 port cleared", 32'h0, {16'h0, flag_0});
	endtask
	// A stray address must neither answer with data nor disturb a flag.
	task unmapped;
		apb(1'b1, 12'h008, 32'hffffffff);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b0, 12'h008, 32'h0);
		chk("unmapped data", 32'h0, rd);
		apb(1'b0, A1, 32'h0);
		chk("status_1 untouched", 32'h0, rd);
	endtask
	// A reset in mid-run must clear every flag at once, not at the next edge.
	task reset_clear;
		apb(1'b1, A0, 32'hffffffff);
		apb(1'b1, A1, 32'hffffffff);
		@(posedge ref_clk);
		chk("status_1 port set", 32'h0000fe1f, {16'h0, flag_1});
		rst <= 1'b1;
		@(posedge ref_clk);
		chk("status_0 port in reset", 32'h0, {16'h0, flag_0});
		chk("status_1 port in reset", 32'h0, {16'h0, flag_1});
		rst <= 1'b0;
		apb(1'b0, A1, 32'h0);
		chk("status_1 after reset", 32'h0, rd);
	endtask
	// With the clock enable low neither an event nor a write may touch a flag.
	task freeze;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		events <= '{status_0: 16'h0008, status_1: 16'h0001};
		@(posedge ref_clk);
		events <= '0;
		apb(1'b1, A1, 32'hffffffff);
		@(posedge ref_clk);
		chk("status_0 frozen", 32'h0, {16'h0, flag_0});
		chk("status_1 frozen", 32'h0, {16'h0, flag_1});
		clk_en <= 1'b1;
		apb(1'b0, A1, 32'h0);
		chk("status_1 after freeze", 32'h0, rd);
	endtask
	// A one-cycle event must leave a sticky flag that only software clears.
	task event_flag(input logic [11:0] a, input logic [15:0] s0, input logic [15:0] s1);
		@(posedge ref_clk);
		events <= '{status_0: s0, status_1: s1};
		@(posedge ref_clk);
		events <= '0;
		apb(1'b0, a, 32'h0);
		chk("flag after event", {16'h0, s0 | s1}, rd);
		apb(1'b0, a, 32'h0);
		chk("flag still held", {16'h0, s0 | s1}, rd);
		apb(1'b1, a, 32'h0);
		apb(1'b0, a, 32'h0);
		chk("flag after clear", 32'h0, rd);
	endtask
	// Main sequence after a reset of twelve cycles.
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, A0, 32'h0);
		chk("status_0 reset", 32'h0, rd);
		apb(1'b0, A1, 32'h0);
		chk("status_1 reset", 32'h0, rd);
		write_masks();
		unmapped();
		reset_clear();
		freeze();
		event_flag(A0, 16'h0080, 16'h0);
		event_flag(A1, 16'h0, 16'h4000);
		event_flag(A1, 16'h0, 16'h2000);
		event_flag(A1, 16'h0, 16'h1000);
		event_flag(A1, 16'h0, 16'h0800);
		event_flag(A1, 16'h0, 16'h0008);
		event_flag(A1, 16'h0, 16'h0010);
		wrap_up();
	end
endmodule
